// >>> hw/urq_pkg.sv
// Package of constants for the receive qualification and baud block
package urq_pkg;
  // Serial modes
  localparam logic [1:0] MODE0           = 2'h0;
  localparam logic [1:0] MODE1           = 2'h1;
  localparam logic [1:0] MODE2           = 2'h2;
  localparam logic [1:0] MODE3           = 2'h3;
  // Divider figures for the bit rates
  localparam int         M0_SLOW_DIV     = 12;
  localparam int         M0_FAST_DIV     = 2;
  localparam int         M2_SLOW_DIV     = 64;
  localparam int         M2_FAST_DIV     = 32;
  localparam int         T1_PRESCALE     = 12;
  localparam int         T1_SPAN         = 256;
  localparam int         M13_DIV_SLOW    = 32;
  localparam int         M13_DIV_FAST    = 16;
  localparam int         OVS_PER_BIT     = 16;
  // Reset values and counter width
  localparam logic [7:0] ADDR_RESET      = 8'h00;
  localparam logic [7:0] MASK_RESET      = 8'h00;
  localparam logic [7:0] TIMER_RESET     = 8'h00;
  localparam int         CNT_W           = 8;
endpackage

// >>> hw/urq_baud.sv
// Bit-rate tick generator for all four serial modes
`timescale 1ns/1ns
module urq_baud #(
  parameter int CNT_W = urq_pkg::CNT_W
) (
  input  wire logic       sys_clk,
  input  wire logic       rst,
  input  wire logic [1:0] mode,
  input  wire logic       baud_doubler,
  input  wire logic       mode0_fast_select,
  input  wire logic [7:0] timer1_reload_value,
  output logic            bit_tick,
  output logic            t1_overflow
);
  // ----------------------------------------
  // Timer 1 model: prescale by 12, count from reload to 256
  // ----------------------------------------
  logic [CNT_W-1:0] pre;
  logic [7:0]       t1;
  logic [CNT_W-1:0] div;
  logic [CNT_W-1:0] target;
  logic             pre_wrap;
  logic             t1_wrap;
  logic             fixed_mode;

  assign pre_wrap   = (pre == CNT_W'(urq_pkg::T1_PRESCALE - 1));
  assign t1_wrap    = pre_wrap && (t1 == 8'(urq_pkg::T1_SPAN - 1));
  assign fixed_mode = (mode == urq_pkg::MODE0) || (mode == urq_pkg::MODE2);

  // Divider target per mode; modes 1/3 count overflows, others clocks
  assign target = (mode == urq_pkg::MODE0) ?
                    (mode0_fast_select ? CNT_W'(urq_pkg::M0_FAST_DIV - 1)
                                       : CNT_W'(urq_pkg::M0_SLOW_DIV - 1)) :
                  (mode == urq_pkg::MODE2) ?
                    (baud_doubler ? CNT_W'(urq_pkg::M2_FAST_DIV - 1)
                                  : CNT_W'(urq_pkg::M2_SLOW_DIV - 1)) :
                    (baud_doubler ? CNT_W'(urq_pkg::M13_DIV_FAST - 1)
                                  : CNT_W'(urq_pkg::M13_DIV_SLOW - 1));

  // Prescaler and 8-bit reload counter
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      pre <= '0;
      t1  <= urq_pkg::TIMER_RESET;
    end else begin
      pre <= pre_wrap ? '0 : pre + CNT_W'(1);
      if (t1_wrap) begin
        t1 <= timer1_reload_value;
      end else if (pre_wrap) begin
        t1 <= t1 + 8'h01;
      end
    end
  end

  // ----------------------------------------
  // Bit divider
  // ----------------------------------------
  // Counts only when its source ticks, so a mode change settles in one bit
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      div         <= '0;
      bit_tick    <= 1'b0;
      t1_overflow <= 1'b0;
    end else begin
      t1_overflow <= t1_wrap;
      bit_tick    <= 1'b0;
      if (fixed_mode || t1_wrap) begin
        if (div >= target) begin
          div      <= '0;
          bit_tick <= 1'b1;
        end else begin
          div <= div + CNT_W'(1);
        end
      end
    end
  end
endmodule

// >>> hw/urq_rx_qual.sv
// Receive qualification: frame error, multiprocessor filter, addressing
`timescale 1ns/1ns
// Notes on behaviour
// - With frame error detection on, a missing stop bit sets the frame error flag.
// - Control bit 7 is frame error flag when select is one, else high mode bit.
// - Hardware never clears the frame error flag; only a software write does.
// - Modes 2/3 with multiproc enable: receive done only when ninth bit is one.
// - Multiproc enable ignored in mode 0; mode 1 needs a valid stop bit.
// - Modes 2/3 with enable: done needs ninth bit one and address match.
// - Mode 1 with enable: done needs valid stop bit and address match.
// - Given address is address AND mask; mask zeros are don't care.
// - Broadcast is address OR mask; zero bits are don't care.
// - Reset clears address and mask, which disables address filtering.
// - Mode 0 rate is clock over 12, or over 2 when fast select set.
// - Mode 2 rate is clock over 64, or over 32 with baud doubler.
// - Modes 1/3 rate is 2^doubler/32 times timer 1 overflow rate.
// - Load data and set done only if done was clear and filter passes.
module urq_rx_qual (
  input  wire logic       sys_clk,
  input  wire logic       rst,
  // Configuration
  input  wire logic       mode_low,
  input  wire logic       multiproc_enable,
  input  wire logic       frame_error_select,
  input  wire logic       baud_doubler,
  input  wire logic       mode0_fast_select,
  input  wire logic [7:0] timer1_reload_value,
  // Software writes of control bit 7, address and mask, and the done clear
  input  wire logic       ctl7_wr,
  input  wire logic       ctl7_wdata,
  input  wire logic       addr_wr,
  input  wire logic [7:0] addr_wdata,
  input  wire logic       mask_wr,
  input  wire logic [7:0] mask_wdata,
  input  wire logic       rx_done_clr,
  // Frame end from the shift engine
  input  wire logic       frame_end,
  input  wire logic [7:0] frame_data,
  input  wire logic       frame_ninth,
  input  wire logic       stop_vote,
  // Status
  output logic            serial_control_b7,
  output logic            frame_error_flag,
  output logic            rx_done_flag,
  output logic [7:0]      serial_buffer,
  output logic            rx_ninth_bit,
  output logic [7:0]      slave_address,
  output logic [7:0]      slave_address_mask,
  output logic            bit_tick,
  output logic            t1_overflow
);
  // ----------------------------------------
  // Shared control bit 7 storage
  // ----------------------------------------
  // Decoded mode and selection wires
  logic       mode_select_high;
  logic [1:0] mode;
  logic       is_mode0;
  logic       is_mode1;
  logic [7:0] given;
  logic [7:0] bcast;
  logic [7:0] given_bit_ok;
  logic [7:0] bcast_bit_ok;
  logic       given_hit;
  logic       bcast_hit;
  logic       addr_hit;
  logic       filter_ok;
  logic       missing_stop;
  logic       accept;
  logic       ctl7_to_flag;
  logic       ctl7_to_mode;
  logic       next_frame_err;
  logic       next_mode_high;
  logic       next_b7;
  logic       next_done;
  logic       next_ninth;
  logic [7:0] next_buffer;
  logic [7:0] next_addr;
  logic [7:0] next_mask;

  // The high mode bit always comes from the stored bit, even while bit 7 is the error flag
  assign mode     = {mode_select_high, mode_low};
  assign is_mode0 = (mode == urq_pkg::MODE0);
  assign is_mode1 = (mode == urq_pkg::MODE1);

  // ----------------------------------------
  // Address recognition
  // ----------------------------------------
  assign given = slave_address & slave_address_mask;
  assign bcast = slave_address | slave_address_mask;

  // Per-bit compare; a zero in the mask (given) or in the OR (broadcast) is a don't care
  genvar b;
  for (b = 0; b < $bits(frame_data); b++) begin : g_addr_bit
    assign given_bit_ok[b] = !slave_address_mask[b] || (frame_data[b] == given[b]);
    assign bcast_bit_ok[b] = !bcast[b] || (frame_data[b] == bcast[b]);
  end

  assign given_hit = &given_bit_ok;
  assign bcast_hit = &bcast_bit_ok;
  assign addr_hit  = given_hit || bcast_hit;

  // ----------------------------------------
  // Filter per mode
  // ----------------------------------------
  // Mode 0 ignores the enable; mode 1 wants a good stop and a match;
  // modes 2/3 want ninth bit one and a match. A zero mask makes any byte
  // match, so the plain ninth-bit filter remains after reset.
  // The ninth bit never takes part in the address compare
  assign filter_ok    = !multiproc_enable || is_mode0 ||
                        (is_mode1 ? (stop_vote && addr_hit)
                                  : (frame_ninth && addr_hit));
  // Mode 0 has no stop bit, so it can never report a framing fault
  assign missing_stop = frame_end && !is_mode0 && !stop_vote;
  // A frame arriving while done is still set is dropped, never queued
  assign accept       = frame_end && !rx_done_flag && filter_ok;

  // ----------------------------------------
  // Shared bit 7 decode
  // ----------------------------------------
  // A bit 7 write goes to whichever meaning the select bit shows this cycle
  assign ctl7_to_flag = ctl7_wr && frame_error_select;
  assign ctl7_to_mode = ctl7_wr && !frame_error_select;

  // Set wins over a software clear written in the same cycle
  assign next_frame_err = (missing_stop && frame_error_select) ? 1'b1 :
                          ctl7_to_flag ? ctl7_wdata :
                          frame_error_flag;
  // Mode bit writes are ignored while bit 7 is the error flag
  assign next_mode_high = ctl7_to_mode ? ctl7_wdata : mode_select_high;
  // The view follows the select bit; the hidden meaning keeps its value
  assign next_b7        = frame_error_select ? next_frame_err : next_mode_high;

  // Frame error flag: hardware only ever sets it
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      frame_error_flag <= 1'b0;
    end else begin
      frame_error_flag <= next_frame_err;
    end
  end

  // Stored high mode bit, untouched while bit 7 shows the error flag
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      mode_select_high <= 1'b0;
    end else begin
      mode_select_high <= next_mode_high;
    end
  end

  // Registered view of bit 7, so the output comes straight from a flop
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      serial_control_b7 <= 1'b0;
    end else begin
      serial_control_b7 <= next_b7;
    end
  end

  // ----------------------------------------
  // Address and mask registers
  // ----------------------------------------
  // Software writes land on the next edge; no read-back path lives here
  assign next_addr = addr_wr ? addr_wdata : slave_address;
  assign next_mask = mask_wr ? mask_wdata : slave_address_mask;

  // Both clear on reset, which leaves every address bit a don't care
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      slave_address      <= urq_pkg::ADDR_RESET;
      slave_address_mask <= urq_pkg::MASK_RESET;
    end else begin
      slave_address      <= next_addr;
      slave_address_mask <= next_mask;
    end
  end

  // ----------------------------------------
  // Receive buffer and done flag
  // ----------------------------------------
  // Mode 1 stores the stop bit as the ninth bit; a discarded frame is lost
  // Only the accepting cycle moves the buffer; otherwise it holds
  assign next_done   = accept ? 1'b1 : (rx_done_clr ? 1'b0 : rx_done_flag);
  assign next_buffer = accept ? frame_data : serial_buffer;
  assign next_ninth  = accept ? (is_mode1 ? stop_vote : frame_ninth)
                              : rx_ninth_bit;

  // Set beats a clear in the same cycle, though accept needs done low anyway
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rx_done_flag  <= 1'b0;
      serial_buffer <= 8'h00;
      rx_ninth_bit  <= 1'b0;
    end else begin
      rx_done_flag  <= next_done;
      serial_buffer <= next_buffer;
      rx_ninth_bit  <= next_ninth;
    end
  end

  // ----------------------------------------
  // Bit-rate generator
  // ----------------------------------------
  // Modes 1 and 3 follow timer 1 overflows; 0 and 2 count system clocks
  // Ticks are one clock wide and come straight from the generator's flops
  urq_baud #(
    .CNT_W (urq_pkg::CNT_W)
  ) u_baud (
    .sys_clk             (sys_clk),
    .rst                 (rst),
    .mode                (mode),
    .baud_doubler        (baud_doubler),
    .mode0_fast_select   (mode0_fast_select),
    .timer1_reload_value (timer1_reload_value),
    .bit_tick            (bit_tick),
    .t1_overflow         (t1_overflow)
  );
endmodule

// >>> tb/urq_properties.sv
// Port checker for the receive qualification block
`timescale 1ns/1ns
module urq_properties (
  input wire logic       sys_clk,
  input wire logic       rst,
  input wire logic       mode_low,
  input wire logic       multiproc_enable,
  input wire logic       frame_error_select,
  input wire logic       ctl7_wr,
  input wire logic       ctl7_wdata,
  input wire logic       rx_done_clr,
  input wire logic       frame_end,
  input wire logic [7:0] frame_data,
  input wire logic       frame_ninth,
  input wire logic       stop_vote,
  input wire logic       frame_error_flag,
  input wire logic       rx_done_flag,
  input wire logic [7:0] serial_buffer,
  input wire logic [7:0] slave_address,
  input wire logic [7:0] slave_address_mask,
  input wire logic       bit_tick
);
  logic mode_high;
  // Shadow high mode bit; a write lands only while bit 7 is not the error flag
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) mode_high <= 1'b0;
    else if (ctl7_wr && !frame_error_select) mode_high <= ctl7_wdata;
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  sequence s_take;
    frame_end && !rx_done_flag;
  endsequence
  chk_err_set: assert property (frame_end && !stop_vote && frame_error_select && mode_low
    |=> frame_error_flag) else $error("missing stop bit left error flag low");
  chk_err_sticky: assert property (frame_error_flag && !ctl7_wr |=> frame_error_flag)
    else $error("error flag dropped without a write");
  chk_done_sticky: assert property (rx_done_flag && !rx_done_clr |=> rx_done_flag)
    else $error("receive done dropped without a clear");
  chk_done_load: assert property (s_take ##0 !multiproc_enable
    |=> rx_done_flag && serial_buffer == $past(frame_data)) else $error("frame not loaded");
  chk_buf_kept: assert property (frame_end && rx_done_flag |=> $stable(serial_buffer))
    else $error("buffer overwritten while done was set");
  chk_data_drop: assert property (s_take ##0 multiproc_enable && mode_high && !frame_ninth
    |=> !rx_done_flag) else $error("data byte raised receive done");
  chk_tick_single: assert property (bit_tick |=> !bit_tick)
    else $error("bit tick longer than one cycle");
  chk_addr_reset: assert property ($fell(rst) |-> slave_address == 8'h00
    && slave_address_mask == 8'h00) else $error("address registers not cleared");
endmodule
bind urq_rx_qual urq_properties u_props (.*);

// >>> tb/urq_master_model.sv
// Far-side node handing finished frames to the block
`timescale 1ns/1ns
module urq_master_model (
  input  wire logic       sys_clk,
  output logic            frame_end,
  output logic [7:0]      frame_data,
  output logic            frame_ninth,
  output logic            stop_vote
);
  initial {frame_end, frame_data, frame_ninth, stop_vote} = 11'h000;
  // Between frames the lines show the inverse, so a stale copy cannot pass
  task automatic send(input logic adr, input logic [7:0] d, input logic stp, input int idle);
    repeat (idle) @(negedge sys_clk);
    @(negedge sys_clk);
    {frame_end, frame_data, frame_ninth, stop_vote} = {1'b1, d, adr, stp};
    @(negedge sys_clk);
    {frame_end, frame_data, frame_ninth, stop_vote} = {1'b0, ~d, ~adr, ~stp};
  endtask
endmodule

// >>> tb/tb_top.sv
// Random frames, address filter, error flag and bit rates
`timescale 1ns/1ns
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin \
  $display("BAD %s exp %h got %h", n, e, g); err_count++; end end
module tb_top;
  logic sys_clk, rst, mode_low, multiproc_enable, frame_error_select, baud_doubler;
  logic mode0_fast_select, ctl7_wr, ctl7_wdata, addr_wr, mask_wr, rx_done_clr;
  logic [7:0] timer1_reload_value, addr_wdata, mask_wdata, frame_data, serial_buffer;
  logic [7:0] slave_address, slave_address_mask, sa, sm, buf_exp;
  logic frame_end, frame_ninth, stop_vote, serial_control_b7, frame_error_flag;
  logic rx_done_flag, rx_ninth_bit, bit_tick, t1_overflow, done_exp, nin_exp;
  logic [1:0] cur_m;
  logic [31:0] r;
  logic [7:0] corner [3] = '{8'hC2, 8'hC1, 8'hFD};
  int err_count = 0, tests_run = 0, seed = 32'hB1B8A405;
  urq_rx_qual u_dut (.*);
  urq_master_model u_mst (.*);
  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end
  task automatic tick(input int n);
    repeat (n) @(negedge sys_clk);
  endtask
  // k selects the strobe: control bit 7, address, mask, done clear
  task automatic wr(input int k, input logic [7:0] v);
    @(negedge sys_clk);
    {ctl7_wdata, addr_wdata, mask_wdata} = {v[0], v, v};
    {ctl7_wr, addr_wr, mask_wr, rx_done_clr} = 4'h8 >> k;
    @(negedge sys_clk);
    {ctl7_wr, addr_wr, mask_wr, rx_done_clr} = 4'h0;
  endtask
  task automatic setm(input logic [1:0] m);
    cur_m = m;
    mode_low = m[0];
    wr(0, {7'h00, m[1]});
  endtask
  function automatic logic hit(input logic [7:0] d, a, m);
    return (((d ^ (a & m)) & m) == 8'h00) || (((d ^ (a | m)) & (a | m)) == 8'h00);
  endfunction
  task automatic rx(input logic nin, input logic [7:0] d, input logic stp, input int idle);
    logic ok;
    ok = !multiproc_enable || cur_m == 2'h0 || ((cur_m == 2'h1 ? stp : nin) && hit(d, sa, sm));
    if (ok && !done_exp) begin
      done_exp = 1'b1;
      buf_exp = d;
      nin_exp = (cur_m == 2'h1) ? stp : nin;
    end
    u_mst.send(nin, d, stp, idle);
    `CHK("done", done_exp, rx_done_flag)
    `CHK("buffer", buf_exp, serial_buffer)
    `CHK("ninth", nin_exp, rx_ninth_bit)
  endtask
  // Third spacing of a pulse, so a settings change cannot skew it
  task automatic gap(input bit ovf, input int e);
    int n;
    for (int k = 0; k < 3; k++) begin
      n = 0;
      do begin
        tick(1);
        n++;
      end while ((ovf ? t1_overflow : bit_tick) !== 1'b1 && n < 4000);
      if (n >= 4000) begin
        err_count++;
        report_and_stop;
      end
    end
    `CHK("spacing", e, n)
  endtask
  task automatic report_and_stop;
    if (err_count == 0 && tests_run > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    {rst, mode_low, multiproc_enable, frame_error_select, baud_doubler} = 5'h10;
    {mode0_fast_select, ctl7_wr, ctl7_wdata, addr_wr, mask_wr, rx_done_clr} = 6'h00;
    {timer1_reload_value, addr_wdata, mask_wdata, sa, sm, buf_exp} = 48'hFF0000000000;
    {cur_m, done_exp, nin_exp} = 4'h0;
    tick(12);
    rst = 1'b0;
    tick(1);
    `CHK("address", 8'h00, slave_address)
    `CHK("mask", 8'h00, slave_address_mask)
    setm(2'h0);
    gap(0, 12);
    mode0_fast_select = 1'b1;
    gap(0, 2);
    setm(2'h2);
    gap(0, 64);
    baud_doubler = 1'b1;
    gap(0, 32);
    setm(2'h1);
    gap(1, 12);
    gap(0, 192);
    baud_doubler = 1'b0;
    gap(0, 384);
    timer1_reload_value = 8'hFE;
    gap(1, 24);
    // Every mode; reset address registers first, then a masked address
    multiproc_enable = 1'b1;
    for (int i = 0; i < 160; i++) begin
      r = $random(seed);
      if (i % 40 == 0) setm(2'(i / 40));
      if (i == 40) begin
        sa = 8'hC0;
        sm = 8'hFD;
        wr(1, sa);
        wr(2, sm);
        `CHK("address", sa, slave_address)
      end
      rx(r[8] | (i % 40 < 3), (i % 40 < 3) ? corner[i % 40] : r[7:0], r[9], r[11:10]);
      if (r[12]) begin
        wr(3, 8'h00);
        done_exp = 1'b0;
      end
    end
    // Reset in mid-run must clear the written address and mask
    rst = 1'b1;
    tick(2);
    rst = 1'b0;
    {sa, sm, buf_exp, done_exp, nin_exp} = 26'h0000000;
    tick(1);
    `CHK("address", 8'h00, slave_address)
    `CHK("mask", 8'h00, slave_address_mask)
    setm(2'h3);
    // Missing stop bit sets the error flag; only a write clears it
    frame_error_select = 1'b1;
    rx(1'b1, 8'h3C, 1'b0, 0);
    `CHK("error", 1'b1, frame_error_flag)
    `CHK("bit7", 1'b1, serial_control_b7)
    rx(1'b1, 8'hC1, 1'b1, 0);
    `CHK("error", 1'b1, frame_error_flag)
    wr(0, 8'h00);
    `CHK("error", 1'b0, frame_error_flag)
    frame_error_select = 1'b0;
    tick(1);
    `CHK("bit7", 1'b1, serial_control_b7)
    report_and_stop;
  end
endmodule
